// File: pkg/sfs_consts.svh
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH

// opcodes
`define SFS_OP_NOP        8'h00
`define SFS_OP_WRITE_STATUS_CMD       8'h01
`define SFS_OP_PP         8'h02
`define SFS_OP_PP4        8'h12
`define SFS_OP_WRDI       8'h04
`define SFS_OP_RDSR       8'h05
`define SFS_OP_WRITE_ENABLE_CMD       8'h06
`define SFS_OP_RDCR       8'h15
`define SFS_OP_SE         8'h20
`define SFS_OP_SE4        8'h21
`define SFS_OP_QEN        8'h35
`define SFS_OP_HBE        8'h52
`define SFS_OP_HBE4       8'h5C
`define SFS_OP_CE         8'h60
`define SFS_OP_CE2        8'hC7
`define SFS_OP_RESET_ARM_CMD      8'h66
`define SFS_OP_RST        8'h99
`define SFS_OP_REMS       8'h90
`define SFS_OP_BE         8'hD8
`define SFS_OP_BE4        8'hDC
`define SFS_OP_QEX        8'hF5
`define SFS_OP_PRD        8'h27
`define SFS_OP_PW0        8'h28
`define SFS_OP_PW1        8'h29
`define SFS_OP_PX0        8'hE0
`define SFS_OP_PX1        8'hE1
`define SFS_OP_PX2        8'hE2

// frame lengths in data bits; dummy length in serial clocks
`define SFS_LEN_OP        16'h0008
`define SFS_LEN_SR        16'h0010
`define SFS_LEN_SRCR      16'h0018
`define SFS_LEN_REMS      16'h0020
`define SFS_LEN_ADDR4     16'h0028
`define SFS_LEN_DATA1     16'h0030
`define SFS_LEN_NONE      16'hFFFF
`define SFS_DUMMY_CLKS    16'h0008

// status layout
`define SFS_SR_BUSY       0
`define SFS_SR_WEL        1
`define SFS_SR_BP_LO      2
`define SFS_SR_BP_HI      5
`define SFS_SR_QUAD       6
`define SFS_BP_RESET      4'h0
`define SFS_CFG_RESET     8'h07

// protection geometry
`define SFS_ARRAY_SPAN    26'h200_0000
`define SFS_BLOCK_SPAN    26'h001_0000
`define SFS_BP_ALL        4'hA

// timing
`define SFS_CLK_NS        4
`define SFS_WRITE_STATUS_CMD_NS       40
`define SFS_WRITE_STATUS_CMD_CYC      ((`SFS_WRITE_STATUS_CMD_NS + `SFS_CLK_NS - 1) / `SFS_CLK_NS)

`endif

// File: pkg/sfs_pkg.sv
package sfs_pkg;

	typedef enum logic [2:0] {
		SFS_ARR_NONE,
		SFS_ARR_PROGRAM,
		SFS_ARR_SECTOR,
		SFS_ARR_HALF_BLOCK,
		SFS_ARR_BLOCK,
		SFS_ARR_CHIP
	} sfs_arr_op_t;

	typedef enum logic [1:0] {
		SFS_ST_READY,
		SFS_ST_STATUS_WR,
		SFS_ST_ARRAY
	} sfs_state_t;

endpackage

// File: design/sfs_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfs_consts.svh"

module sfs_core (
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_rst,
	input  wire logic                 i_sclk,
	input  wire logic                 i_cs_n,
	input  wire logic [3:0]           i_io,
	output logic      [3:0]           o_io,
	output logic      [3:0]           o_io_oe_n,
	output logic                      o_op_start,
	output sfs_pkg::sfs_arr_op_t      o_op_kind,
	output logic      [31:0]          o_op_addr,
	input  wire logic                 i_op_done,
	output logic                      o_prot_cmd,
	output logic      [7:0]           o_prot_opcode,
	output logic      [31:0]          o_prot_addr,
	output logic      [7:0]           o_prot_data,
	input  wire logic [7:0]           i_prot_rdata,
	input  wire logic [7:0]           i_maker_id,
	input  wire logic [7:0]           i_device_id,
	output logic      [7:0]           o_status,
	output logic      [7:0]           o_configuration_bits,
	output logic                      o_quad_command_mode,
	output logic                      o_sw_reset
);

	function automatic logic prot_hit(input logic [3:0] lvl, input logic [31:0] a);
		logic [25:0] span;
		begin
			span = `SFS_BLOCK_SPAN << (lvl - 4'h1);
			if (lvl == 4'h0)
				prot_hit = 1'b0;
			else if (lvl >= `SFS_BP_ALL)
				prot_hit = 1'b1;
			else
				prot_hit = {1'b0, a[24:0]} >= (`SFS_ARRAY_SPAN - span);
		end
	endfunction

	function automatic logic [15:0] resp_start(input logic [7:0] op, input logic quad);
		begin
			if (op == `SFS_OP_RDSR || op == `SFS_OP_RDCR)
				resp_start = `SFS_LEN_OP;
			else if (op == `SFS_OP_REMS)
				resp_start = `SFS_LEN_REMS;
			else if (op == `SFS_OP_PRD)
				resp_start = `SFS_LEN_ADDR4 + (quad ? (`SFS_DUMMY_CLKS << 2) : `SFS_DUMMY_CLKS);
			else
				resp_start = `SFS_LEN_NONE;
		end
	endfunction

	// pin synchronisers; the first stage feeds only the second
	logic        sclk_m_q, sclk_s_q, sclk_p_q;
	logic        cs_m_q, cs_s_q, cs_p_q;
	logic [3:0]  io_m_q, io_s_q;

	always_ff @(posedge i_clk_sys or posedge i_rst)
		if (i_rst)
		begin
			sclk_m_q <= 1'b0;
			sclk_s_q <= 1'b0;
			sclk_p_q <= 1'b0;
			cs_m_q   <= 1'b1;
			cs_s_q   <= 1'b1;
			cs_p_q   <= 1'b1;
			io_m_q   <= 4'h0;
			io_s_q   <= 4'h0;
		end
		else
		begin
			sclk_m_q <= i_sclk;
			sclk_s_q <= sclk_m_q;
			sclk_p_q <= sclk_s_q;
			cs_m_q   <= i_cs_n;
			cs_s_q   <= cs_m_q;
			cs_p_q   <= cs_s_q;
			io_m_q   <= i_io;
			io_s_q   <= io_m_q;
		end

	logic rise, fall, fend;
	assign rise = sclk_s_q & ~sclk_p_q & ~cs_s_q;
	assign fall = ~sclk_s_q & sclk_p_q & ~cs_s_q;
	assign fend = cs_s_q & ~cs_p_q;

	logic                 quad_q;
	logic [15:0]          bits_q, bits_d;
	logic [7:0]           sh_q, sh_d, op_q, data1_q, data2_q;
	logic [31:0]          addr_q;
	logic [3:0]           bp_q;
	logic                 wel_q, arm_q;
	logic [7:0]           cfg_q;
	sfs_pkg::sfs_state_t  state_q;
	logic [7:0]           tmr_q;

	// input shifting: four bits a clock in quad command mode, one otherwise
	always_comb
	begin
		bits_d = bits_q;
		sh_d   = sh_q;
		if (rise)
		begin
			bits_d = (bits_q >= 16'hFFF0) ? bits_q : bits_q + (quad_q ? 16'h0004 : 16'h0001);
			sh_d   = quad_q ? {sh_q[3:0], io_s_q} : {sh_q[6:0], io_s_q[0]};
		end
	end

	logic       byte_done;
	logic [15:0] byte_no;
	assign byte_done = rise && (bits_d[2:0] == 3'h0);
	assign byte_no   = bits_d >> 3;

	always_ff @(posedge i_clk_sys or posedge i_rst)
		if (i_rst)
		begin
			bits_q  <= 16'h0000;
			sh_q    <= 8'h00;
			op_q    <= `SFS_OP_NOP;
			addr_q  <= 32'h0000_0000;
			data1_q <= 8'h00;
			data2_q <= 8'h00;
		end
		else if (cs_s_q)
		begin
			bits_q <= 16'h0000;
		end
		else
		begin
			bits_q <= bits_d;
			sh_q   <= sh_d;
			if (byte_done)
			begin
				if (byte_no == 16'h0001)
					op_q <= sh_d;
				// an id read replies from byte 5 on; its address byte must not be pushed out
				else if (byte_no <= 16'h0005 && !(op_q == `SFS_OP_REMS && byte_no == 16'h0005))
					addr_q <= {addr_q[23:0], sh_d};
				if (byte_no == 16'h0002)
					data1_q <= sh_d;
				if (byte_no == 16'h0003)
					data2_q <= sh_d;
				if (byte_no == 16'h0006)
					data1_q <= sh_d;
			end
		end

	// frame-end decode; only whole frames of the right length act
	logic                  busy, aligned;
	logic                  is_one, is_write_enable_cmd, is_wrdi, is_rst, is_write_status_cmd, is_qen, is_qex, is_prot;
	logic                  op_req, op_hit;
	sfs_pkg::sfs_arr_op_t  op_kind;

	assign busy    = (state_q != sfs_pkg::SFS_ST_READY);
	assign aligned = (bits_q[2:0] == 3'h0);
	assign is_one  = fend && (bits_q == `SFS_LEN_OP) && !busy;
	assign is_write_enable_cmd = is_one && op_q == `SFS_OP_WRITE_ENABLE_CMD;
	assign is_wrdi = is_one && op_q == `SFS_OP_WRDI;
	assign is_rst  = is_one && op_q == `SFS_OP_RST && arm_q;
	assign is_qen  = is_one && op_q == `SFS_OP_QEN;
	assign is_qex  = is_one && op_q == `SFS_OP_QEX;
	assign is_write_status_cmd = fend && !busy && wel_q && op_q == `SFS_OP_WRITE_STATUS_CMD
		&& (bits_q == `SFS_LEN_SR || bits_q == `SFS_LEN_SRCR);
	assign is_prot = fend && !busy && !quad_q && aligned && bits_q >= `SFS_LEN_DATA1
		&& (op_q == `SFS_OP_PX2 || op_q == `SFS_OP_PX1 || op_q == `SFS_OP_PX0
		|| op_q == `SFS_OP_PW0 || op_q == `SFS_OP_PW1);

	always_comb
	begin
		op_kind = sfs_pkg::SFS_ARR_NONE;
		op_req  = 1'b0;
		if (fend && !busy)
		begin
			if ((op_q == `SFS_OP_PP || op_q == `SFS_OP_PP4) && aligned
				&& bits_q >= `SFS_LEN_DATA1)
				op_kind = sfs_pkg::SFS_ARR_PROGRAM;
			else if ((op_q == `SFS_OP_SE || op_q == `SFS_OP_SE4) && bits_q == `SFS_LEN_ADDR4)
				op_kind = sfs_pkg::SFS_ARR_SECTOR;
			else if ((op_q == `SFS_OP_HBE || op_q == `SFS_OP_HBE4) && bits_q == `SFS_LEN_ADDR4)
				op_kind = sfs_pkg::SFS_ARR_HALF_BLOCK;
			else if ((op_q == `SFS_OP_BE || op_q == `SFS_OP_BE4) && bits_q == `SFS_LEN_ADDR4)
				op_kind = sfs_pkg::SFS_ARR_BLOCK;
			else if ((op_q == `SFS_OP_CE || op_q == `SFS_OP_CE2) && bits_q == `SFS_LEN_OP)
				op_kind = sfs_pkg::SFS_ARR_CHIP;
			op_req = (op_kind != sfs_pkg::SFS_ARR_NONE) && wel_q;
		end
	end

	// chip erase only with level zero; others check the target address
	assign op_hit = (op_kind == sfs_pkg::SFS_ARR_CHIP) ? (bp_q != 4'h0)
		: prot_hit(bp_q, addr_q);

	// arm survives only until the next whole opcode byte
	always_ff @(posedge i_clk_sys or posedge i_rst)
		if (i_rst)
			arm_q <= 1'b0;
		else if (fend && bits_q >= `SFS_LEN_OP)
			arm_q <= (op_q == `SFS_OP_RESET_ARM_CMD) && (bits_q == `SFS_LEN_OP);

	always_ff @(posedge i_clk_sys or posedge i_rst)
		if (i_rst)
			quad_q <= 1'b0;
		else if (is_rst || is_qex)
			quad_q <= 1'b0;
		else if (is_qen)
			quad_q <= 1'b1;

	// busy sequencing
	always_ff @(posedge i_clk_sys or posedge i_rst)
		if (i_rst)
		begin
			state_q <= sfs_pkg::SFS_ST_READY;
			tmr_q   <= 8'h00;
		end
		else
		begin
			case (state_q)
				sfs_pkg::SFS_ST_READY:
					if (is_write_status_cmd)
					begin
						state_q <= sfs_pkg::SFS_ST_STATUS_WR;
						tmr_q   <= 8'(`SFS_WRITE_STATUS_CMD_CYC - 1);
					end
					else if (op_req && !op_hit)
						state_q <= sfs_pkg::SFS_ST_ARRAY;
				sfs_pkg::SFS_ST_STATUS_WR:
					if (tmr_q == 8'h00)
						state_q <= sfs_pkg::SFS_ST_READY;
					else
						tmr_q <= tmr_q - 8'h01;
				sfs_pkg::SFS_ST_ARRAY:
					if (i_op_done)
						state_q <= sfs_pkg::SFS_ST_READY;
				default:
					state_q <= sfs_pkg::SFS_ST_READY;
			endcase
		end

	// write-enable latch; completion clear takes priority only over no event
	always_ff @(posedge i_clk_sys or posedge i_rst)
		if (i_rst)
			wel_q <= 1'b0;
		else if (is_write_enable_cmd)
			wel_q <= 1'b1;
		else if (is_wrdi || is_rst)
			wel_q <= 1'b0;
		else if (op_req && op_hit)
			wel_q <= 1'b0;
		else if (state_q == sfs_pkg::SFS_ST_ARRAY && i_op_done)
			wel_q <= 1'b0;
		else if (state_q == sfs_pkg::SFS_ST_STATUS_WR && tmr_q == 8'h00)
			wel_q <= 1'b0;

	// protect level is kept across soft reset, as it models stored bits
	always_ff @(posedge i_clk_sys or posedge i_rst)
		if (i_rst)
		begin
			bp_q  <= `SFS_BP_RESET;
			cfg_q <= `SFS_CFG_RESET;
		end
		else if (is_rst)
			cfg_q <= `SFS_CFG_RESET;
		else if (is_write_status_cmd)
		begin
			bp_q <= data1_q[`SFS_SR_BP_HI:`SFS_SR_BP_LO];
			if (bits_q == `SFS_LEN_SRCR)
				cfg_q <= data2_q;
		end

	// requests toward the array and the protection logic
	always_ff @(posedge i_clk_sys or posedge i_rst)
		if (i_rst)
		begin
			o_op_start    <= 1'b0;
			o_op_kind     <= sfs_pkg::SFS_ARR_NONE;
			o_op_addr     <= 32'h0000_0000;
			o_prot_cmd    <= 1'b0;
			o_prot_opcode <= 8'h00;
			o_prot_addr   <= 32'h0000_0000;
			o_prot_data   <= 8'h00;
			o_sw_reset    <= 1'b0;
		end
		else
		begin
			o_op_start <= op_req && !op_hit;
			o_prot_cmd <= is_prot;
			o_sw_reset <= is_rst;
			if (op_req && !op_hit)
			begin
				o_op_kind <= op_kind;
				o_op_addr <= addr_q;
			end
			if (is_prot)
			begin
				o_prot_opcode <= op_q;
				o_prot_addr   <= addr_q;
				o_prot_data   <= data1_q;
			end
		end

	assign o_status = {1'b0, 1'b1, bp_q, wel_q, busy};

	// read replies, shifted out on the falling serial clock
	logic [15:0] rs, k;
	logic [7:0]  rbyte, tx_q;
	logic [3:0]  io_q;
	logic        drive_q;

	assign rs = resp_start(op_q, quad_q);
	assign k  = (bits_q - rs) >> 3;

	always_comb
	begin
		if (op_q == `SFS_OP_RDSR)
			rbyte = o_status;
		else if (op_q == `SFS_OP_RDCR)
			rbyte = cfg_q;
		else if (op_q == `SFS_OP_REMS)
			rbyte = (k[0] ^ addr_q[0]) ? i_device_id : i_maker_id;
		else
			rbyte = i_prot_rdata;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
		if (i_rst)
		begin
			tx_q    <= 8'h00;
			io_q    <= 4'h0;
			drive_q <= 1'b0;
		end
		else if (cs_s_q)
		begin
			drive_q <= 1'b0;
			io_q    <= 4'h0;
		end
		else if (fall && rs != `SFS_LEN_NONE && bits_q >= rs)
		begin
			drive_q <= 1'b1;
			if (((bits_q - rs) & 16'h0007) == 16'h0000)
			begin
				tx_q <= quad_q ? {rbyte[3:0], 4'h0} : {rbyte[6:0], 1'b0};
				io_q <= quad_q ? rbyte[7:4] : {2'b00, rbyte[7], 1'b0};
			end
			else
			begin
				tx_q <= quad_q ? {tx_q[3:0], 4'h0} : {tx_q[6:0], 1'b0};
				io_q <= quad_q ? tx_q[7:4] : {2'b00, tx_q[7], 1'b0};
			end
		end

	assign o_io                 = io_q;
	assign o_io_oe_n            = !drive_q ? 4'hF : (quad_q ? 4'h0 : 4'hD);
	assign o_configuration_bits = cfg_q;
	assign o_quad_command_mode  = quad_q;

endmodule

`default_nettype wire

// File: verif/sfs_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sfs_core_properties (
	input wire logic                 i_clk_sys,
	input wire logic                 i_rst,
	input wire logic                 i_op_done,
	input wire logic                 o_op_start,
	input wire sfs_pkg::sfs_arr_op_t o_op_kind,
	input wire logic                 o_prot_cmd,
	input wire logic [7:0]           o_status,
	input wire logic                 o_quad_command_mode,
	input wire logic                 o_sw_reset
);
	default clocking dc @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	chk_status_top: assert property (o_status[7:6] == 2'b01)
		else $error("status bits 7:6 wrong");
	chk_start_busy: assert property (o_op_start |=> o_status[0])
		else $error("busy not set after op start");
	chk_start_wel: assert property (o_op_start |-> $past(o_status[1]) && !$past(o_status[0]))
		else $error("op started without latch or while busy");
	chk_done_clear: assert property (i_op_done && o_status[0] |=> o_status[1:0] == 2'b00)
		else $error("done left busy or latch set");
	// chip erase is the one op that needs the whole level clear
	chk_chip_level: assert property (o_op_start && o_op_kind == sfs_pkg::SFS_ARR_CHIP
		|-> o_status[5:2] == 4'h0)
		else $error("chip erase started with protection");
	chk_level_write: assert property ($changed(o_status[5:2]) |-> o_status[0] || $past(o_status[0]))
		else $error("protect level moved outside a status write");
	chk_reset_clears: assert property (o_sw_reset |=> !o_status[1] && !o_quad_command_mode)
		else $error("soft reset left latch or quad mode");
	chk_prot_single: assert property (o_prot_cmd |-> !o_quad_command_mode)
		else $error("protection command taken in quad mode");

	cover property (o_op_start && o_op_kind == sfs_pkg::SFS_ARR_CHIP);
	cover property (o_sw_reset);
	cover property (o_prot_cmd);
endmodule
bind sfs_core sfs_core_properties i_chk (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_op_done(i_op_done), .o_op_start(o_op_start),
	.o_op_kind(o_op_kind), .o_prot_cmd(o_prot_cmd), .o_status(o_status),
	.o_quad_command_mode(o_quad_command_mode), .o_sw_reset(o_sw_reset)
);
`default_nettype wire

// File: verif/sfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfs_host_model (
	input  wire logic i_clk_sys,
	input  wire logic i_miso,
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic [3:0] o_io
);
	initial
	begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_io   = 4'h0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	// msb first, a nibble a clock in quad mode; sclk stays low between frames
	task automatic frame(input logic [63:0] tx, input int nclk, input bit q, output logic [63:0] rx);
		rx = '0;
		o_cs_n <= 1'b0;
		for (int k = 0; k < nclk; k++)
		begin
			wait_clk(20);
			o_sclk <= 1'b0;
			o_io <= q ? tx[63:60] : {~o_io[3:1], tx[63]};
			tx = q ? tx << 4 : tx << 1;
			wait_clk(20);
			o_sclk <= 1'b1;
			rx = {rx[62:0], i_miso};
		end
		wait_clk(20);
		o_sclk <= 1'b0;
		wait_clk(20);
		o_cs_n <= 1'b1;
		// released lines must not keep showing the last bit
		o_io <= ~o_io;
		wait_clk(60);
	endtask
endmodule
`default_nettype wire

// File: verif/serial_flash_status_and_reset_test.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_status_and_reset_test;
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	logic                 op_done = 1'b0;
	logic                 sclk, cs_n, op_st, pc, qm, swr;
	logic [3:0]           hio, pin, oi, oe_n;
	logic [7:0]           prd = 8'h00, mid = 8'h00, did = 8'h00, st, cfg, pop, pdat, c;
	logic [31:0]          oad, pad, a;
	logic [63:0]          rx;
	sfs_pkg::sfs_arr_op_t kind;
	int                   fail_count = 0, n_checks = 0, n_st = 0, n_rs = 0, n_pc = 0;
	int                   write_enable_latch = 0, bp = 0, qd = 0;
	logic [7:0]           pops [5] = '{8'hE2, 8'hE1, 8'hE0, 8'h28, 8'h29};

	always #2 clk = ~clk;
	assign pin = (oi & ~oe_n) | (hio & oe_n);
	sfs_core i_dut (
		.i_clk_sys(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_io(pin),
		.o_io(oi), .o_io_oe_n(oe_n), .o_op_start(op_st), .o_op_kind(kind), .o_op_addr(oad),
		.i_op_done(op_done), .o_prot_cmd(pc), .o_prot_opcode(pop), .o_prot_addr(pad),
		.o_prot_data(pdat), .i_prot_rdata(prd), .i_maker_id(mid), .i_device_id(did),
		.o_status(st), .o_configuration_bits(cfg), .o_quad_command_mode(qm), .o_sw_reset(swr)
	);
	sfs_host_model i_host (
		.i_clk_sys(clk), .i_miso(pin[1]), .o_sclk(sclk), .o_cs_n(cs_n), .o_io(hio)
	);
	always @(posedge clk)
	begin
		n_st <= n_st + op_st;
		n_rs <= n_rs + swr;
		n_pc <= n_pc + pc;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_st(input logic [7:0] g);
		chk("status", {24'h0, 2'b01, bp[3:0], write_enable_latch[0], 1'b0}, g);
	endtask
	// only defined opcodes are ever sent
	task automatic send(input logic [63:0] tx, input int n);
		i_host.frame(tx, n, qd[0], rx);
	endtask
	task automatic write_enable_cmd();
		send({8'h06, 56'h0}, 8);
		write_enable_latch = 1;
	endtask
	task automatic pulse_done();
		@(posedge clk);
		op_done <= 1'b1;
		@(posedge clk);
		op_done <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge clk);
		fail_count++;
		test_done();
	end
	initial
	begin
		void'($urandom(40));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		prd <= 8'($urandom);
		mid <= 8'($urandom);
		did <= 8'($urandom);
		repeat (4) @(posedge clk);
		chk_st(st);
		chk("config", 8'h07, cfg);
		$display("test reset done");
		a = $urandom;
		send({8'h20, a, 24'h0}, 40);
		chk("starts", 0, n_st);
		send({8'h06, 56'h0}, 4);
		chk_st(st);
		write_enable_cmd();
		send({8'h05, 56'h0}, 16);
		chk_st(rx[7:0]);
		send({8'h20, a, 24'h0}, 40);
		chk("starts", 1, n_st);
		chk("kind", sfs_pkg::SFS_ARR_SECTOR, kind);
		chk("addr", a, oad);
		send({8'h05, 56'h0}, 16);
		chk("busy", 1, rx[0]);
		pulse_done();
		write_enable_latch = 0;
		send({8'h05, 56'h0}, 16);
		chk_st(rx[7:0]);
		$display("test erase done");
		c = 8'($urandom);
		write_enable_cmd();
		send({8'h01, 8'h28, c, 40'h0}, 24);
		bp = 10;
		write_enable_latch = 0;
		chk_st(st);
		chk("config", c, cfg);
		for (int i = 0; i < 2; i++)
		begin
			write_enable_cmd();
			send({i ? 8'h60 : 8'h20, a, 24'h0}, i ? 8 : 40);
			write_enable_latch = 0;
			chk("starts", 1, n_st);
			chk_st(st);
		end
		write_enable_cmd();
		send({8'h01, 56'h0}, 16);
		bp = 0;
		write_enable_cmd();
		send({8'h60, 56'h0}, 8);
		pulse_done();
		write_enable_latch = 0;
		chk("starts", 2, n_st);
		chk("kind", sfs_pkg::SFS_ARR_CHIP, kind);
		chk_st(st);
		$display("test protect done");
		foreach (pops[i])
		begin
			a = $urandom;
			c = 8'($urandom);
			send({pops[i], a, c, 16'h0}, 48);
			chk("p_op", pops[i], pop);
			chk("p_addr", a, pad);
			chk("p_data", c, pdat);
		end
		chk("p_cmds", 5, n_pc);
		send({8'h27, a, 24'h0}, 56);
		chk("p_read", prd, rx[7:0]);
		for (int j = 0; j < 2; j++)
		begin
			send({8'h90, 16'h0, j[7:0], 32'h0}, 48);
			chk("ids", j ? {did, mid} : {mid, did}, rx[15:0]);
		end
		$display("test groups done");
		send({8'h35, 56'h0}, 8);
		qd = 1;
		chk("quad", 1, qm);
		send({8'h66, 56'h0}, 2);
		send({8'h99, 56'h0}, 2);
		qd = 0;
		chk("resets", 1, n_rs);
		chk("quad", 0, qm);
		chk("config", 8'h07, cfg);
		write_enable_cmd();
		send({8'h66, 56'h0}, 8);
		send({8'h00, 56'h0}, 8);
		send({8'h99, 56'h0}, 8);
		chk("resets", 1, n_rs);
		chk_st(st);
		$display("test soft reset done");
		test_done();
	end
endmodule
`default_nettype wire
